// File: logic/csr_pkg.sv
// Package for the core special register bank: map, fields, reset values, timing
// Function
// R1: A low reset pin resets ports and peripherals, then fetch restarts at address 0.
// R2: Reset pin level is sampled during power-on to request in-system programming.
// R3: Pin is a reset during power-on or when configured, else an input-only port bit.
// R4: Port 1 bit 0 can carry the serial transmitter output instead of port data.
// R5: Port 1 bit 1 supplies the serial receiver input.
// R6: Software never accesses undefined special register addresses.
// R7: Software uses each defined register only for its own function.
// R8: Reserved bits are written zero; reads may return anything.
// R9: Fixed-zero bits read zero and are written zero.
// R10: Fixed-one bits read one and are written one.
// R11: A flash control write delivers an eight-bit command code, not status.
// R12: Flash control reads busy in bit 7, four fault flags in 3..0; reset 70 hex.
// R13: Auxiliary register: clock select 7, toggle 4, soft reset 3, zero 2, pointer 0.
// R14: Core clock divider is an eight-bit register resetting to zero.
// R15: Data pointer is high and low bytes at consecutive addresses, reset zero.
// R16: Flash address is high and low bytes, both resetting to zero.
// R17: First high-priority register: watchdog 6, brownout 5, timer 1 3, timer 0 1.
// R18: Second high-priority register: comparator bit 2, keypad bit 1.
// R19: Bit-addressable registers accept single-bit access at base address plus bit.
package csr_pkg;
  localparam int NSLOT = 18;
  localparam int ADDR_W = 12;
  // Register byte offsets as seen by the core; APB byte address is four times this
  localparam logic [7:0] SFR_ADDR [NSLOT] = '{8'h82, 8'h83, 8'h94, 8'h95, 8'ha2, 8'ha8, 8'hac, 8'hb7, 8'hb8,
    8'he0, 8'he4, 8'he5, 8'he6, 8'he7, 8'he8, 8'hf0, 8'hf7, 8'hf8};
  // Storable bits; everything else reads zero, except flash control status and comparator level bit 1
  localparam logic [7:0] SFR_WMASK [NSLOT] = '{8'hff, 8'hff, 8'h03, 8'hff, 8'h91, 8'hea, 8'h29, 8'h6a, 8'h6a,
    8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'h06, 8'hff, 8'h06, 8'h06};
  localparam logic [7:0] SFR_RST [NSLOT] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [NSLOT-1:0] SFR_BITADDR = 18'h2c320;
  localparam logic [4:0] SL_PTRLO = 5'h00, SL_PTRHI = 5'h01, SL_KB = 5'h02, SL_DIV = 5'h03, SL_AUX = 5'h04;
  localparam logic [4:0] SL_ENA1 = 5'h05, SL_CMP = 5'h06, SL_PRIHI1 = 5'h07, SL_PRILO1 = 5'h08, SL_ACC = 5'h09;
  localparam logic [4:0] SL_FMC = 5'h0a, SL_FMD = 5'h0b, SL_FAL = 5'h0c, SL_FAH = 5'h0d, SL_ENA2 = 5'h0e;
  localparam logic [4:0] SL_MULOP = 5'h0f, SL_PRIHI2 = 5'h10, SL_PRILO2 = 5'h11, SL_NONE = 5'h12;
  localparam logic [7:0] FLASH_CTL_RST = 8'h70;
  // Word indices of the bit window and of the local registers
  localparam logic [2:0] BIT_WIN = 3'h3;
  localparam logic [9:0] IDX_STAT = 10'h200, IDX_MASK = 10'h201, IDX_CFG = 10'h202;
  localparam int AUX_LPCLK = 7, AUX_T0TOGGLE = 4, AUX_SOFTRST = 3, AUX_PTRSEL = 0;
  localparam int FLAG_BIT = 0, CMP_OUT = 1;
  localparam int CFG_RSTEN = 0, CFG_TXSEL = 1, CFG_ISP = 7;
  localparam logic [7:0] CFG_WMASK = 8'h03;
  localparam int NEV = 6;
  localparam int EV_FLASH = 0, EV_SWRST = 1, EV_PINRST = 2, EV_KEY = 3, EV_CMP = 4, EV_BAD = 5;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int POR_TIME_NS = 1600;
  localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic busy;
    logic high_voltage_abort;
    logic high_voltage_error;
    logic security_violation;
    logic operation_interrupted;
  } csr_fstat_s;

  typedef struct packed {
    logic [15:0] data_pointer;
    logic [15:0] flash_address;
    logic [7:0] flash_data;
    logic [7:0] core_clock_divider;
    logic [7:0] accumulator;
    logic [7:0] multiply_operand;
    logic [7:0] ien_first;
    logic [7:0] ien_second;
    logic [7:0] pri_low_first;
    logic [7:0] pri_high_first;
    logic [7:0] pri_low_second;
    logic [7:0] pri_high_second;
    logic low_power_clock_select;
    logic timer_zero_pin_toggle_enable;
    logic pointer_select;
  } csr_ctl_s;

  // Slot of a register offset, SL_NONE when undefined
  function automatic logic [4:0] slot_of(input logic [7:0] a);
    logic [4:0] s;
    s = SL_NONE;
    for (int i = 0; i < NSLOT; i++) begin
      if (SFR_ADDR[i] == a) begin
        s = 5'(i);
      end
    end
    return s;
  endfunction
endpackage

// File: logic/csr_bank.sv
// Special register bank behind an APB slave, with reset pin and serial pin logic
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module csr_bank #(
  parameter int POR_CYCLES = csr_pkg::POR_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [csr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire csr_pkg::csr_fstat_s flash_stat,
  output logic flash_cmd_valid,
  output logic [7:0] flash_cmd_code,
  input wire logic keypad_event,
  input wire logic cmp_event,
  input wire logic cmp_level,
  output csr_pkg::csr_ctl_s ctl,
  input wire logic rst_pin,
  input wire logic rxd_pin,
  input wire logic uart_txd,
  input wire logic p10_port_out,
  input wire logic p10_port_oe,
  output logic p10_out,
  output logic p10_oe,
  output logic uart_rxd,
  output logic p15_port_in,
  output logic core_reset,
  output logic fetch_restart,
  output logic [15:0] fetch_addr,
  output logic isp_entry,
  output logic sw_reset,
  output logic irq
);
  logic [7:0] sfr_r [csr_pkg::NSLOT];
  logic [1:0] s1_r, s2_r, s3_r, pin_r;
  logic [15:0] por_cnt_r;
  logic isp_r, core_reset_r, fetch_restart_r, sw_reset_r;
  logic pready_r, pslverr_r, fcmd_v_r, irq_r, p10_out_r, p10_oe_r, p15_r;
  logic [31:0] prdata_r;
  logic [7:0] fcmd_r, cfg_r;
  logic [csr_pkg::NEV-1:0] stat_r, mask_r, ev;

  // Pin synchronisers: bit 1 receiver pin, bit 0 reset pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 2'h3;
      s2_r <= 2'h3;
      s3_r <= 2'h3;
      pin_r <= 2'h3;
    end else begin
      s1_r <= {rxd_pin, rst_pin};
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_r <= (s2_r & s3_r) | (pin_r & (s2_r ^ s3_r)); // Accept only when stages agree
    end
  end

  // Power-on window; the pin is always a reset inside it
  wire por_act = por_cnt_r != 16'h0000;
  wire rst_act = !pin_r[0] && (por_act || cfg_r[csr_pkg::CFG_RSTEN]); // R3
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_cnt_r <= 16'(POR_CYCLES);
      isp_r <= 1'b0;
    end else if (por_act) begin
      por_cnt_r <= por_cnt_r - 16'h0001;
      if (por_cnt_r == 16'h0001) begin
        isp_r <= !pin_r[0]; // R2
      end
    end
  end

  // Core reset from the pin or the soft trigger; restart pulse at release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reset_r <= 1'b1;
      fetch_restart_r <= 1'b0;
    end else begin
      core_reset_r <= rst_act || sw_reset_r; // R1
      fetch_restart_r <= core_reset_r && !(rst_act || sw_reset_r); // R1
    end
  end

  // Address decode: word index, bit window or byte register
  wire [9:0] idx = paddr[csr_pkg::ADDR_W-1:2];
  wire is_bit = idx[9:7] == csr_pkg::BIT_WIN;
  wire is_sfr = idx[9:8] == 2'h0;
  wire [2:0] bitn = idx[2:0];
  wire [7:0] raddr = is_bit ? {idx[7:3], 3'h0} : idx[7:0];
  wire [4:0] slot = csr_pkg::slot_of(raddr);
  wire slot_ok = slot != csr_pkg::SL_NONE;
  wire sfr_hit = slot_ok && (is_sfr || (is_bit && csr_pkg::SFR_BITADDR[slot])); // R19
  wire own_hit = idx == csr_pkg::IDX_STAT || idx == csr_pkg::IDX_MASK || idx == csr_pkg::IDX_CFG;
  wire hit = sfr_hit || own_hit;
  wire acc = psel && penable;
  wire ans = acc && pready_r;
  wire we = ans && pwrite && hit;
  wire sfr_we = we && sfr_hit;

  // Read view of the addressed slot; unstored bits read zero, except flash control status and comparator level bit 1
  wire [7:0] fm_rd = csr_pkg::FLASH_CTL_RST | {flash_stat.busy, 3'h0, flash_stat.high_voltage_abort,
    flash_stat.high_voltage_error, flash_stat.security_violation, flash_stat.operation_interrupted}; // R12
  wire [7:0] slot_rd = !slot_ok ? 8'h00 : slot == csr_pkg::SL_FMC ? fm_rd :
    slot == csr_pkg::SL_CMP ? (sfr_r[slot] | {6'h00, cmp_level, 1'b0}) : sfr_r[slot]; // R8 R9 R10
  wire [7:0] bm = 8'h01 << bitn;
  wire [7:0] wbyte = is_bit ? ((slot_rd & ~bm) | (pwdata[0] ? bm : 8'h00)) : pwdata[7:0]; // R19
  wire [7:0] own_rd = idx == csr_pkg::IDX_STAT ? 8'(stat_r) : idx == csr_pkg::IDX_MASK ? 8'(mask_r) :
    idx == csr_pkg::IDX_CFG ? (cfg_r | {isp_r, 7'h00}) : 8'h00;
  wire [7:0] rd = own_hit ? own_rd : !sfr_hit ? 8'h00 : is_bit ? {7'h00, slot_rd[bitn]} : slot_rd;

  // One wait state so read data and the answer come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= acc && !pready_r;
      pslverr_r <= acc && !pready_r && !hit;
      if (acc && !pready_r) begin
        prdata_r <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd};
      end
    end
  end

  // Stored registers, one process per slot; hardware flag sets win over writes
  for (genvar g = 0; g < csr_pkg::NSLOT; g++) begin : g_slot
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sfr_r[g] <= csr_pkg::SFR_RST[g];
      end else if (core_reset_r) begin
        sfr_r[g] <= csr_pkg::SFR_RST[g]; // R1 R14 R15 R16
      end else begin
        if (sfr_we && slot == 5'(g)) begin
          sfr_r[g] <= wbyte & csr_pkg::SFR_WMASK[g]; // R13 R17 R18
        end
        if (5'(g) == csr_pkg::SL_KB && keypad_event) begin
          sfr_r[g][csr_pkg::FLAG_BIT] <= 1'b1;
        end
        if (5'(g) == csr_pkg::SL_CMP && cmp_event) begin
          sfr_r[g][csr_pkg::FLAG_BIT] <= 1'b1;
        end
      end
    end
  end

  // Flash command strobe and soft reset pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcmd_v_r <= 1'b0;
      fcmd_r <= 8'h00;
      sw_reset_r <= 1'b0;
    end else begin
      fcmd_v_r <= sfr_we && slot == csr_pkg::SL_FMC; // R11
      if (sfr_we && slot == csr_pkg::SL_FMC) begin
        fcmd_r <= wbyte; // R11
      end
      sw_reset_r <= sfr_we && slot == csr_pkg::SL_AUX && wbyte[csr_pkg::AUX_SOFTRST]; // R13
    end
  end

  // Events into the sticky status; set beats a one written to clear
  assign ev[csr_pkg::EV_FLASH] = sfr_we && slot == csr_pkg::SL_FMC;
  assign ev[csr_pkg::EV_SWRST] = sfr_we && slot == csr_pkg::SL_AUX && wbyte[csr_pkg::AUX_SOFTRST];
  assign ev[csr_pkg::EV_PINRST] = rst_act && !core_reset_r;
  assign ev[csr_pkg::EV_KEY] = keypad_event;
  assign ev[csr_pkg::EV_CMP] = cmp_event;
  assign ev[csr_pkg::EV_BAD] = ans && !hit;
  wire [csr_pkg::NEV-1:0] w1c = (we && idx == csr_pkg::IDX_STAT) ? pwdata[csr_pkg::NEV-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= '0;
      mask_r <= '0;
      cfg_r <= 8'h00;
      irq_r <= 1'b0;
    end else begin
      stat_r <= (stat_r & ~w1c) | ev;
      if (we && idx == csr_pkg::IDX_MASK) begin
        mask_r <= pwdata[csr_pkg::NEV-1:0];
      end
      if (we && idx == csr_pkg::IDX_CFG) begin
        cfg_r <= pwdata[7:0] & csr_pkg::CFG_WMASK;
      end
      irq_r <= |(stat_r & mask_r);
    end
  end

  // Pin sharing: transmitter onto port 1 bit 0, reset pin as port bit 5
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p10_out_r <= 1'b1;
      p10_oe_r <= 1'b0;
      p15_r <= 1'b1;
    end else begin
      p10_out_r <= cfg_r[csr_pkg::CFG_TXSEL] ? uart_txd : p10_port_out; // R4
      p10_oe_r <= cfg_r[csr_pkg::CFG_TXSEL] || p10_port_oe; // R4
      p15_r <= (por_act || cfg_r[csr_pkg::CFG_RSTEN]) ? 1'b1 : pin_r[0]; // R3
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign flash_cmd_valid = fcmd_v_r;
  assign flash_cmd_code = fcmd_r;
  assign p10_out = p10_out_r;
  assign p10_oe = p10_oe_r;
  assign uart_rxd = pin_r[1]; // R5
  assign p15_port_in = p15_r;
  assign core_reset = core_reset_r;
  assign fetch_restart = fetch_restart_r;
  assign fetch_addr = csr_pkg::RESET_VECTOR;
  assign isp_entry = isp_r;
  assign sw_reset = sw_reset_r;
  assign irq = irq_r;
  // Control view of the stored registers
  assign ctl.data_pointer = {sfr_r[csr_pkg::SL_PTRHI], sfr_r[csr_pkg::SL_PTRLO]}; // R15
  assign ctl.flash_address = {sfr_r[csr_pkg::SL_FAH], sfr_r[csr_pkg::SL_FAL]}; // R16
  assign ctl.flash_data = sfr_r[csr_pkg::SL_FMD];
  assign ctl.core_clock_divider = sfr_r[csr_pkg::SL_DIV];
  assign ctl.accumulator = sfr_r[csr_pkg::SL_ACC];
  assign ctl.multiply_operand = sfr_r[csr_pkg::SL_MULOP];
  assign ctl.ien_first = sfr_r[csr_pkg::SL_ENA1];
  assign ctl.ien_second = sfr_r[csr_pkg::SL_ENA2];
  assign ctl.pri_low_first = sfr_r[csr_pkg::SL_PRILO1];
  assign ctl.pri_high_first = sfr_r[csr_pkg::SL_PRIHI1];
  assign ctl.pri_low_second = sfr_r[csr_pkg::SL_PRILO2];
  assign ctl.pri_high_second = sfr_r[csr_pkg::SL_PRIHI2];
  assign ctl.low_power_clock_select = sfr_r[csr_pkg::SL_AUX][csr_pkg::AUX_LPCLK];
  assign ctl.timer_zero_pin_toggle_enable = sfr_r[csr_pkg::SL_AUX][csr_pkg::AUX_T0TOGGLE];
  assign ctl.pointer_select = sfr_r[csr_pkg::SL_AUX][csr_pkg::AUX_PTRSEL];

  // Checks on the bank's own outputs
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_ans = ans && !pwrite;
  apb_wait_a: assert property (acc && !pready |=> pready ##1 !pready)
    else $error("answer not after one wait");
  bad_addr_a: assert property (acc && !pready && !hit |=> pslverr && pready)
    else $error("unmapped access not flagged");
  flash_read_a: assert property (rd_ans && sfr_hit && !is_bit && slot == csr_pkg::SL_FMC |->
    prdata[6:4] == 3'h7 && prdata[31:8] == 24'h00_0000) else $error("flash status read wrong"); // R12
  flash_cmd_a: assert property (sfr_we && slot == csr_pkg::SL_FMC |=>
    flash_cmd_valid && flash_cmd_code == $past(pwdata[7:0]) ##1 !flash_cmd_valid)
    else $error("flash command not delivered"); // R11
  aux_zero_a: assert property (rd_ans && sfr_hit && !is_bit && slot == csr_pkg::SL_AUX |->
    prdata[2] == 1'b0) else $error("fixed zero bit read one"); // R9
  soft_rst_a: assert property (sfr_we && slot == csr_pkg::SL_AUX && pwdata[3] |=>
    sw_reset ##1 core_reset ##1 ctl.core_clock_divider == 8'h00) else $error("soft reset lost"); // R13
  div_write_a: assert property (sfr_we && !is_bit && slot == csr_pkg::SL_DIV && !core_reset |=>
    ctl.core_clock_divider == $past(pwdata[7:0])) else $error("divider write lost"); // R14
  bit_write_a: assert property (sfr_we && is_bit && slot == csr_pkg::SL_ACC && !core_reset |=>
    ctl.accumulator[$past(bitn)] == $past(pwdata[0])) else $error("bit write lost"); // R19
  pin_reset_a: assert property (rst_act |=> core_reset) else $error("pin reset ignored"); // R1
  restart_a: assert property ($fell(core_reset) |-> fetch_restart && fetch_addr == 16'h0000)
    else $error("no restart at zero"); // R1
  irq_level_a: assert property (|(stat_r & mask_r) |=> irq) else $error("interrupt not raised");
  tx_route_a: assert property (cfg_r[csr_pkg::CFG_TXSEL] |=> p10_oe && p10_out == $past(uart_txd))
    else $error("transmitter not on pin"); // R4
  c_bit_c: cover property (sfr_we && is_bit);
  c_flash_c: cover property (flash_cmd_valid);
  c_pinrst_c: cover property ($fell(core_reset) && !por_act);
  c_irq_c: cover property ($rose(irq));
endmodule
`default_nettype wire

// File: bench/csr_core_model.sv
// Processor core model: APB master reaching the special register bank
`timescale 1ns/1ps
`default_nettype none
module csr_core_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [csr_pkg::ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
  end

  // One transfer; request held until pready is seen at a rising edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic err, output logic ok);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    // Answer taken at the same edge that ends the access
    q = prdata;
    err = pslverr;
    ok = (pready === 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// File: bench/core_special_register_bank_tb_top.sv
// Bench for the special register bank: reset values, fields, pins, interrupt
`timescale 1ns/1ps
`default_nettype none
module core_special_register_bank_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic [csr_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  csr_pkg::csr_fstat_s flash_stat;
  csr_pkg::csr_ctl_s ctl;
  logic flash_cmd_valid, keypad_event, cmp_event, cmp_level, rst_pin, rxd_pin, uart_txd;
  logic p10_port_out, p10_port_oe, p10_out, p10_oe, uart_rxd, p15_port_in, core_reset;
  logic fetch_restart, isp_entry, sw_reset, irq;
  logic [7:0] flash_cmd_code;
  logic [15:0] fetch_addr;
  int err_total, cmp_count;

  csr_core_model core (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Short power-on window keeps the run brief, yet outlasts the pin synchroniser
  csr_bank #(.POR_CYCLES(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_stat(flash_stat), .flash_cmd_valid(flash_cmd_valid), .flash_cmd_code(flash_cmd_code),
    .keypad_event(keypad_event), .cmp_event(cmp_event), .cmp_level(cmp_level), .ctl(ctl),
    .rst_pin(rst_pin), .rxd_pin(rxd_pin), .uart_txd(uart_txd), .p10_port_out(p10_port_out),
    .p10_port_oe(p10_port_oe), .p10_out(p10_out), .p10_oe(p10_oe), .uart_rxd(uart_rxd),
    .p15_port_in(p15_port_in), .core_reset(core_reset), .fetch_restart(fetch_restart),
    .fetch_addr(fetch_addr), .isp_entry(isp_entry), .sw_reset(sw_reset), .irq(irq));

  // Clock, 100 ns period
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic complete_run();
    if (err_total == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Word index access; a lost answer ends the run
  task automatic acc(input logic wr, input logic [9:0] idx, input logic [31:0] d);
    logic ok;
    core.xfer(wr, {idx, 2'b00}, d, q, last_err, ok);
    if (ok !== 1'b1) begin
      chk("pready", 32'h1, 32'h0);
      complete_run();
    end
  endtask

  task automatic rdc(input string nm, input logic [9:0] idx, input logic [31:0] exp);
    acc(1'b0, idx, 32'h0);
    chk(nm, exp, q);
  endtask

  // Bounded wait for a level on a design output
  task automatic wait_lvl(input string nm, ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (s !== v) begin
      chk(nm, 32'(v), 32'(s));
      complete_run();
    end
  endtask

  task automatic t_reset_values();
    logic [7:0] offs [6] = '{8'h95, 8'h82, 8'h83, 8'he6, 8'he7, 8'he5};
    foreach (offs[i]) rdc("reset value", {2'b00, offs[i]}, 32'h0);
    rdc("flash control reset", 10'h0e4, 32'h70);
  endtask

  task automatic t_pointer();
    acc(1'b1, 10'h083, 32'h12);
    acc(1'b1, 10'h082, 32'h34);
    @(posedge pclk);
    chk("data pointer", 32'h1234, 32'(ctl.data_pointer));
    acc(1'b1, 10'h0e7, 32'hab);
    acc(1'b1, 10'h0e6, 32'hcd);
    @(posedge pclk);
    chk("flash address", 32'habcd, 32'(ctl.flash_address));
    acc(1'b1, 10'h095, 32'h5a);
    rdc("divider", 10'h095, 32'h5a);
  endtask

  task automatic t_flash();
    acc(1'b1, 10'h0e4, 32'ha5);
    wait_lvl("command strobe", flash_cmd_valid, 1'b1, 4);
    chk("command code", 32'ha5, 32'(flash_cmd_code));
    rdc("flash status idle", 10'h0e4, 32'h70);
    flash_stat <= 5'b10010;
    rdc("flash status busy", 10'h0e4, 32'hf2);
    flash_stat <= 5'b01101;
    rdc("flash status faults", 10'h0e4, 32'h7d);
    flash_stat <= 5'b00000;
  endtask

  // Soft reset clears the bank, so it runs after the field checks
  task automatic t_aux();
    acc(1'b1, 10'h0a2, 32'h91);
    rdc("auxiliary", 10'h0a2, 32'h91);
    chk("clock select", 32'h1, 32'(ctl.low_power_clock_select));
    chk("pointer select", 32'h1, 32'(ctl.pointer_select));
    acc(1'b1, 10'h0b7, 32'h6a);
    rdc("priority high first", 10'h0b7, 32'h6a);
    acc(1'b1, 10'h0f7, 32'h06);
    rdc("priority high second", 10'h0f7, 32'h06);
    acc(1'b1, 10'h0a2, 32'h08);
    wait_lvl("soft reset", sw_reset, 1'b1, 6);
    wait_lvl("core reset high", core_reset, 1'b1, 4);
    wait_lvl("core reset low", core_reset, 1'b0, 30);
    repeat (3) @(posedge pclk);
    rdc("divider after soft reset", 10'h095, 32'h0);
    rdc("auxiliary after soft reset", 10'h0a2, 32'h0);
  endtask

  // Refused access raises a sticky flag; irq checked under both mask settings
  task automatic t_bad_irq();
    acc(1'b1, 10'h200, 32'h3f);
    rdc("unmapped read", 10'h081, 32'h0);
    chk("unmapped error", 32'h1, 32'(last_err));
    acc(1'b0, 10'h200, 32'h0);
    chk("bad access flag", 32'h1, 32'(q[5]));
    acc(1'b1, 10'h201, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq masked", 32'h0, 32'(irq));
    acc(1'b1, 10'h201, 32'h3f);
    repeat (2) @(posedge pclk);
    chk("irq unmasked", 32'h1, 32'(irq));
    acc(1'b1, 10'h200, 32'h20);
    repeat (2) @(posedge pclk);
    chk("irq after clear", 32'h0, 32'(irq));
  endtask

  task automatic t_bit();
    acc(1'b1, 10'h1e3, 32'h1);
    rdc("accumulator by bit", 10'h0e0, 32'h08);
    rdc("bit read", 10'h1e3, 32'h1);
  endtask

  task automatic t_pins();
    acc(1'b1, 10'h202, 32'h02);
    uart_txd <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("tx pin high", 32'h3, {30'h0, p10_oe, p10_out});
    uart_txd <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("tx pin low", 32'h0, 32'(p10_out));
    rxd_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("rx data low", 32'h0, 32'(uart_rxd));
    rxd_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("rx data high", 32'h1, 32'(uart_rxd));
  endtask

  task automatic t_pin_reset();
    acc(1'b1, 10'h202, 32'h00);
    rst_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("pin as port", 32'h0, {30'h0, core_reset, p15_port_in});
    rst_pin <= 1'b1;
    acc(1'b1, 10'h095, 32'h33);
    acc(1'b1, 10'h202, 32'h01);
    rst_pin <= 1'b0;
    wait_lvl("pin reset", core_reset, 1'b1, 10);
    rst_pin <= 1'b1;
    wait_lvl("fetch restart", fetch_restart, 1'b1, 20);
    chk("fetch address", 32'h0, 32'(fetch_addr));
    repeat (3) @(posedge pclk);
    rdc("divider after pin reset", 10'h095, 32'h0);
  endtask

  // Second power-up with the pin held low; the synchroniser restarts at its idle level
  task automatic t_isp();
    rst_pin <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wait_lvl("isp entry", isp_entry, 1'b1, 12);
    chk("reset during power-on", 32'h1, 32'(core_reset));
    rst_pin <= 1'b1;
    wait_lvl("core reset after power-on", core_reset, 1'b0, 12);
    repeat (2) @(posedge pclk);
  endtask

  // Keypad and comparator pulses set their flags and the sticky status
  task automatic t_events();
    keypad_event <= 1'b1;
    cmp_event <= 1'b1;
    cmp_level <= 1'b1;
    @(posedge pclk);
    keypad_event <= 1'b0;
    cmp_event <= 1'b0;
    rdc("keypad flag", 10'h094, 32'h01);
    rdc("comparator flag and level", 10'h0ac, 32'h03);
    acc(1'b0, 10'h200, 32'h0);
    chk("event status", 32'h3, 32'(q[4:3]));
  endtask

  initial begin
    err_total = 0;
    cmp_count = 0;
    presetn = 1'b0;
    flash_stat = '0;
    keypad_event = 1'b0;
    cmp_event = 1'b0;
    cmp_level = 1'b0;
    rst_pin = 1'b1;
    rxd_pin = 1'b1;
    uart_txd = 1'b1;
    p10_port_out = 1'b1;
    p10_port_oe = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    chk("power-on isp", 32'h0, 32'(isp_entry));
    t_reset_values();
    t_pointer();
    t_flash();
    t_aux();
    t_bad_irq();
    t_bit();
    t_pins();
    t_pin_reset();
    t_isp();
    t_events();
    complete_run();
  end
endmodule
`default_nettype wire
